/* inc/sfr_pkg.sv */
// Shared constants and types for the serial flash read path
package sfr_pkg;
  localparam logic [7:0] OP_CONT_READ = 8'hE8; // Continuous array read
  localparam logic [7:0] OP_PAGE_READ = 8'hD2; // Single page read
  localparam logic [7:0] OP_BUF1_READ = 8'hD4; // First buffer read
  localparam logic [7:0] OP_BUF2_READ = 8'hD6; // Second buffer read
  localparam int PAGE_BITS = 13; // Page number width
  localparam int BYTE_BITS = 10; // Byte in page width
  localparam int PAGE_BYTES = 528; // Bytes per page and per buffer
  localparam logic [12:0] LAST_PAGE = 13'h1FFF; // Highest page number
  localparam logic [9:0] LAST_BYTE = 10'h20F; // Last byte of page or buffer
  localparam logic [7:0] ADDR_BITS = 8'h18; // Address field length
  localparam logic [7:0] MEM_DUMMY = 8'h20; // Dummy clocks for array reads
  localparam logic [7:0] BUF_DUMMY = 8'h08; // Dummy clocks for buffer reads
  localparam int MEM_WORDS = 4096; // Modelled array bytes, low pages only
  localparam int HALF_DIV = 6; // Host link clock half period in mclk cycles
  localparam int FIFO_DEPTH = 16; // Host receive FIFO depth
  localparam int FIFO_WIDTH = 8; // Host receive FIFO width
  // Device frame phases, Gray along opcode, address, dummy, data
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPC = 3'b001,
    ST_ADR = 3'b011,
    ST_DUM = 3'b010,
    ST_DAT = 3'b110,
    ST_IGN = 3'b111
  } sfr_state_t;
endpackage : sfr_pkg

/* inc/sfr_if.sv */
// Serial link between host and flash read path
`timescale 1ns/1ps
interface sfr_if;
  logic cs_n; // Chip select, low active
  logic sck; // Serial clock
  logic si; // Host to device data
  logic so_o; // Device driven output value
  logic so_oe; // Device output enable
  logic so; // Resolved output line
  assign so = so_oe ? so_o : 1'b1;
  modport dev (input cs_n, input sck, input si, output so_o, output so_oe);
  modport host (output cs_n, output sck, output si, input so);
endinterface : sfr_if

/* logic/sfr_fifo.sv */
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
module sfr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, low active
  input wire logic in_valid, // Write request
  output logic in_ready, // Space available
  input wire logic [WIDTH-1:0] in_data, // Write word
  output logic out_valid, // Word available
  input wire logic out_ready, // Reader takes word
  output logic [WIDTH-1:0] out_data // Head word
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sfr_fifo_st_t;
  sfr_fifo_st_t st_reg, st_next;
  logic [WIDTH-1:0] mem [DEPTH]; // Storage
  logic [AW:0] count; // Fill level
  assign count = st_reg.wp - st_reg.rp;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data = mem[st_reg.rp[AW-1:0]];
  // Pointer update
  always_comb
  begin
    st_next = st_reg;
    if (in_valid && in_ready)
      st_next.wp = st_reg.wp + 1'b1;
    if (out_valid && out_ready)
      st_next.rp = st_reg.rp + 1'b1;
  end
  // Storage write, no reset needed
  always_ff @(posedge mclk)
  begin
    if (in_valid && in_ready)
      mem[st_reg.wp[AW-1:0]] <= in_data;
  end
  // State register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
endmodule : sfr_fifo

/* logic/sfr_dev.sv */
// Device end: read command decoder and serial output shifter
`timescale 1ns/1ps
module sfr_dev (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, low active
  sfr_if.dev link, // Serial pins
  input wire logic buf_wr_en, // User buffer load strobe
  input wire logic buf_wr_sel, // 0 first buffer, 1 second
  input wire logic [9:0] buf_wr_addr, // Buffer byte offset
  input wire logic [7:0] buf_wr_data, // Byte to load
  input wire logic mem_wr_en, // User array load strobe
  input wire logic [22:0] mem_wr_addr, // Page and byte address
  input wire logic [7:0] mem_wr_data, // Byte to load
  output logic busy // Frame in progress
);
  typedef struct packed {
    logic [1:0] cs_s; // Select synchroniser
    logic [1:0] sck_s; // Clock synchroniser
    logic [1:0] si_s; // Data synchroniser
    logic sck_d; // Previous synced clock
    sfr_pkg::sfr_state_t st; // Frame phase
    logic [7:0] cnt; // Bits left in phase
    logic [23:0] sh; // Input shift register
    logic [1:0] kind; // 0 cont, 1 page, 2 buf1, 3 buf2
    logic [12:0] page; // Current page
    logic [9:0] byt; // Current byte
    logic [2:0] bit_n; // Next bit index
    logic [7:0] dbyte; // Byte being sent
    logic so_o; // Output bit
    logic so_oe; // Output enable
  } sfr_dev_st_t;
  sfr_dev_st_t r_reg, r_next;
  logic [7:0] mem [sfr_pkg::MEM_WORDS]; // Array model, low pages only
  logic [7:0] buf1 [sfr_pkg::PAGE_BYTES]; // First buffer
  logic [7:0] buf2 [sfr_pkg::PAGE_BYTES]; // Second buffer
  logic [22:0] flat; // Flat array address of current byte
  logic [22:0] wr_flat; // Flat array address of a preload byte
  logic [7:0] fetch; // Byte at current address
  logic rise; // Synced clock rising edge
  logic fall; // Synced clock falling edge
  logic cs_hi; // Synced select high
  logic [23:0] sh_in; // Shift register with new bit
  logic [9:0] byt_inc; // Next byte offset
  assign link.so_o = r_reg.so_o;
  assign link.so_oe = r_reg.so_oe;
  assign busy = (r_reg.st != sfr_pkg::ST_IDLE);
  assign rise = r_reg.sck_s[1] && !r_reg.sck_d;
  assign fall = !r_reg.sck_s[1] && r_reg.sck_d;
  assign cs_hi = r_reg.cs_s[1];
  assign sh_in = {r_reg.sh[22:0], r_reg.si_s[1]};
  assign flat = r_reg.page * 23'(sfr_pkg::PAGE_BYTES) + 23'(r_reg.byt);
  // Preload uses the same page and byte folding as reads, so both alias alike
  assign wr_flat = mem_wr_addr[22:10] * 23'(sfr_pkg::PAGE_BYTES) + 23'(mem_wr_addr[9:0]);
  // Byte fetch; array reads read the array only, buffers untouched
  always_comb
  begin
    case (r_reg.kind)
      2'h2: fetch = buf1[r_reg.byt];
      2'h3: fetch = buf2[r_reg.byt];
      default: fetch = mem[flat[11:0]];
    endcase
  end
  // Offset after current byte, wrapping to zero after the last byte for every command
  always_comb
  begin
    byt_inc = (r_reg.byt == sfr_pkg::LAST_BYTE) ? 10'h000 : r_reg.byt + 10'h001;
  end
  // User side loading of array and buffers (no serial write commands)
  always_ff @(posedge mclk)
  begin
    if (mem_wr_en)
      mem[wr_flat[11:0]] <= mem_wr_data;
    if (buf_wr_en && !buf_wr_sel)
      buf1[buf_wr_addr] <= buf_wr_data;
    if (buf_wr_en && buf_wr_sel)
      buf2[buf_wr_addr] <= buf_wr_data;
  end
  // Frame sequencer: data sampled on rising, output changed on falling edges
  always_comb
  begin
    r_next = r_reg;
    r_next.cs_s = {r_reg.cs_s[0], link.cs_n};
    r_next.sck_s = {r_reg.sck_s[0], link.sck};
    r_next.si_s = {r_reg.si_s[0], link.si};
    r_next.sck_d = r_reg.sck_s[1];
    if (cs_hi)
    begin
      r_next.st = sfr_pkg::ST_IDLE;
      r_next.so_oe = 1'b0;
    end
    else
    begin
      case (r_reg.st)
        sfr_pkg::ST_IDLE:
        begin
          // Select low opens a frame; idle clock level gives mode 0 or 3
          r_next.st = sfr_pkg::ST_OPC;
          r_next.cnt = 8'h08;
          r_next.so_oe = 1'b0;
        end
        sfr_pkg::ST_OPC:
          if (rise)
          begin
            r_next.sh = sh_in;
            r_next.cnt = r_reg.cnt - 8'h01;
            if (r_reg.cnt == 8'h01)
            begin
              r_next.cnt = sfr_pkg::ADDR_BITS;
              r_next.st = sfr_pkg::ST_ADR;
              case (sh_in[7:0])
                sfr_pkg::OP_CONT_READ: r_next.kind = 2'h0;
                sfr_pkg::OP_PAGE_READ: r_next.kind = 2'h1;
                sfr_pkg::OP_BUF1_READ: r_next.kind = 2'h2;
                sfr_pkg::OP_BUF2_READ: r_next.kind = 2'h3;
                default: r_next.st = sfr_pkg::ST_IGN;
              endcase
            end
          end
        sfr_pkg::ST_ADR:
          if (rise)
          begin
            r_next.sh = sh_in;
            r_next.cnt = r_reg.cnt - 8'h01;
            if (r_reg.cnt == 8'h01)
            begin
              r_next.st = sfr_pkg::ST_DUM;
              if (r_reg.kind[1])
              begin
                r_next.page = '0;
                r_next.byt = sh_in[9:0];
                r_next.cnt = sfr_pkg::BUF_DUMMY;
              end
              else
              begin
                r_next.page = sh_in[22:10];
                r_next.byt = sh_in[9:0];
                r_next.cnt = sfr_pkg::MEM_DUMMY;
              end
            end
          end
        sfr_pkg::ST_DUM:
          if (rise)
          begin
            r_next.cnt = r_reg.cnt - 8'h01;
            if (r_reg.cnt == 8'h01)
            begin
              r_next.st = sfr_pkg::ST_DAT;
              r_next.dbyte = fetch;
              r_next.bit_n = 3'h7;
            end
          end
        sfr_pkg::ST_DAT:
          if (fall)
          begin
            // Drive one bit per falling edge, highest first
            r_next.so_oe = 1'b1;
            r_next.so_o = r_reg.dbyte[r_reg.bit_n];
            r_next.bit_n = r_reg.bit_n - 3'h1;
            if (r_reg.bit_n == 3'h0)
            begin
              r_next.byt = byt_inc;
              if (r_reg.kind == 2'h0 && r_reg.byt == sfr_pkg::LAST_BYTE)
                r_next.page = (r_reg.page == sfr_pkg::LAST_PAGE) ? 13'h0000
                  : r_reg.page + 13'h0001;
            end
          end
          else if (rise && r_reg.bit_n == 3'h7 && r_reg.so_oe)
            r_next.dbyte = fetch; // Next byte, no stall at page end
        sfr_pkg::ST_IGN:
          r_next.so_oe = 1'b0;
        default:
          r_next.st = sfr_pkg::ST_IDLE;
      endcase
    end
  end
  // State register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_reg <= '0;
      r_reg.cs_s <= 2'h3;
      r_reg.st <= sfr_pkg::ST_IDLE;
    end
    else
      r_reg <= r_next;
  end
endmodule : sfr_dev

/* logic/sfr_host.sv */
// Host end: issues a read frame and collects bytes into a FIFO
`timescale 1ns/1ps
module sfr_host (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, low active
  sfr_if.host link, // Serial pins
  input wire logic start, // Pulse: begin a read frame
  input wire logic [7:0] opcode, // Read opcode to send
  input wire logic [23:0] addr, // Address field
  input wire logic [7:0] dummy_bits, // Dummy clocks to send
  input wire logic [15:0] nbytes, // Bytes to read
  output logic busy, // Frame in progress
  output logic rx_valid, // Byte available
  input wire logic rx_ready, // User takes byte
  output logic [7:0] rx_data // Received byte
);
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_SEND = 2'b01, H_RECV = 2'b11, H_END = 2'b10} sfr_h_t;
  typedef struct packed {
    sfr_h_t st; // Phase
    logic [1:0] so_s; // Input synchroniser
    logic [39:0] tx; // Outgoing bits
    logic [7:0] tx_n; // Outgoing bits left
    logic [15:0] rx_n; // Bytes left
    logic [7:0] rx; // Incoming byte
    logic [2:0] bit_n; // Bits in byte
    logic [3:0] div; // Clock divider
    logic sck; // Serial clock out
    logic cs_n; // Select out
    logic push; // FIFO write pulse
    logic [7:0] pdata; // FIFO write data
  } sfr_host_st_t;
  sfr_host_st_t r_reg, r_next;
  logic f_ready; // FIFO space
  logic tick; // Half period elapsed
  assign link.cs_n = r_reg.cs_n;
  assign link.sck = r_reg.sck;
  assign link.si = r_reg.tx[39];
  assign busy = (r_reg.st != H_IDLE);
  assign tick = (r_reg.div == 4'(sfr_pkg::HALF_DIV - 1));
  sfr_fifo #(.WIDTH(sfr_pkg::FIFO_WIDTH), .DEPTH(sfr_pkg::FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(r_reg.push),
    .in_ready(f_ready),
    .in_data(r_reg.pdata),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );
  // Mode 0 master; pauses clock while FIFO full for back-pressure
  always_comb
  begin
    r_next = r_reg;
    r_next.so_s = {r_reg.so_s[0], link.so};
    r_next.push = 1'b0;
    r_next.div = tick ? 4'h0 : r_reg.div + 4'h1;
    case (r_reg.st)
      H_IDLE:
        if (start)
        begin
          r_next.cs_n = 1'b0;
          r_next.tx = {opcode, addr, 8'h00};
          r_next.tx_n = 8'h08 + sfr_pkg::ADDR_BITS + dummy_bits; // Opcode, address, dummy
          r_next.rx_n = nbytes;
          r_next.bit_n = 3'h0;
          r_next.div = 4'h0;
          r_next.st = H_SEND;
        end
      H_SEND, H_RECV:
        if (tick && !(r_reg.st == H_RECV && !r_reg.sck && !f_ready))
        begin
          r_next.sck = !r_reg.sck;
          if (r_reg.sck)
          begin
            // Falling edge: advance
            if (r_reg.st == H_SEND)
            begin
              r_next.tx = {r_reg.tx[38:0], 1'b0};
              r_next.tx_n = r_reg.tx_n - 8'h01;
              if (r_reg.tx_n == 8'h01)
                r_next.st = (r_reg.rx_n == 16'h0000) ? H_END : H_RECV;
            end
          end
          else if (r_reg.st == H_RECV)
          begin
            // Rising edge: sample, highest bit first
            r_next.rx = {r_reg.rx[6:0], r_reg.so_s[1]};
            r_next.bit_n = r_reg.bit_n + 3'h1;
            if (r_reg.bit_n == 3'h7)
            begin
              r_next.push = 1'b1;
              r_next.pdata = {r_reg.rx[6:0], r_reg.so_s[1]};
              r_next.rx_n = r_reg.rx_n - 16'h0001;
              if (r_reg.rx_n == 16'h0001)
                r_next.st = H_END;
            end
          end
        end
      H_END:
        if (tick)
        begin
          r_next.sck = 1'b0;
          r_next.cs_n = 1'b1;
          r_next.st = H_IDLE;
        end
      default:
        r_next.st = H_IDLE;
    endcase
  end
  // State register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_reg <= '0;
      r_reg.cs_n <= 1'b1;
    end
    else
      r_reg <= r_next;
  end
endmodule : sfr_host

/* tb/sfr_checker.sv */
// Link checker for the host and device ends of the flash read path
`timescale 1ns/1ps
module sfr_checker (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, low active
  input wire logic cs_n, // Select, low active
  input wire logic sck, // Link clock
  input wire logic si, // Host data
  input wire logic so_o, // Device bit
  input wire logic so_oe, // Device enable
  input wire logic so // Resolved line
);
  logic sck_reg; // Last sck sample
  logic [7:0] opc_reg; // Opcode of this frame
  logic [6:0] edge_reg; // Rising edges, saturating
  logic [3:0] age_reg; // Cycles since sck fell
  logic rd_op; // Array read opcode
  logic known_op; // Any read opcode
  assign rd_op = (opc_reg == sfr_pkg::OP_CONT_READ) || (opc_reg == sfr_pkg::OP_PAGE_READ);
  assign known_op = rd_op || (opc_reg == sfr_pkg::OP_BUF1_READ)
    || (opc_reg == sfr_pkg::OP_BUF2_READ);
  // Frame bookkeeping; edges only count while selected
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_reg <= 1'b0;
      opc_reg <= 8'h00;
      edge_reg <= 7'h00;
      age_reg <= 4'hF;
    end
    else
    begin
      sck_reg <= sck;
      // Saturates so a long pause cannot wrap into a false recent fall
      age_reg <= (sck_reg && !sck) ? 4'h0 : ((age_reg == 4'hF) ? age_reg : age_reg + 4'h1);
      if (cs_n)
        edge_reg <= 7'h00;
      else if (sck && !sck_reg && edge_reg != 7'h7F)
        edge_reg <= edge_reg + 7'h01;
      if (!cs_n && sck && !sck_reg && edge_reg < 7'h08)
        opc_reg <= {opc_reg[6:0], si};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_FLOAT_AT_END: assert property ($rose(cs_n) |-> ##[0:3] (!so_oe && so))
    else $error("output still driven after deselect");
  AST_FLOAT_HEAD: assert property ((!cs_n && edge_reg < 7'h28) |-> !so_oe)
    else $error("output driven before data phase");
  AST_ARRAY_DUMMY: assert property ((!cs_n && rd_op && edge_reg < 7'h40) |-> !so_oe)
    else $error("array read drove output inside dummy clocks");
  AST_UNKNOWN_QUIET: assert property ((!cs_n && edge_reg >= 7'h08 && !known_op) |-> !so_oe)
    else $error("unknown opcode drove output");
  AST_DATA_AFTER_FALL: assert property ($rose(so_oe) |-> !cs_n && age_reg <= 4'h5)
    else $error("output enabled away from a clock fall");
  AST_BIT_STANDS: assert property ((so_oe && $past(so_oe) && $changed(so_o)) |-> age_reg <= 4'h5)
    else $error("data bit changed away from a clock fall");
  AST_SCK_LOW_AT_SELECT: assert property ($fell(cs_n) |-> !sck)
    else $error("link clock high at frame start");
  AST_SCK_ONLY_SELECTED: assert property ($changed(sck) |-> !(cs_n && $past(cs_n)))
    else $error("link clock moved while deselected");
  AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n [*3])
    else $error("deselect gap too short");
  AST_SCK_HIGH_TIME: assert property ($rose(sck) |-> sck [*6] ##1 !sck)
    else $error("link clock high phase not six cycles");
endmodule : sfr_checker

/* tb/testbench.sv */
// Bench joining both link ends and checking read frames
`timescale 1ns/1ps
`define SFR_CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, got, exp); end end
module testbench;
  logic mclk, rst_n, start, rx_ready, bw_en, bw_sel, mw_en; // Bench driven controls
  logic [9:0] bw_addr; // Buffer offset
  logic [22:0] mw_addr; // Page and byte
  logic [7:0] wdata, opcode, dummy_bits, rx_data, seen_opc; // Byte wide signals
  logic [23:0] addr; // Address field
  logic [15:0] nbytes; // Byte count
  logic hbusy, rx_valid; // Host status
  logic dbusy; // Device frame in progress
  logic [7:0] q[$]; // Bytes received
  int mismatches, checks_done, fcnt; // Counters
  sfr_if link ();
  sfr_dev sfr_dev_i (.mclk(mclk), .rst_n(rst_n), .link(link), .buf_wr_en(bw_en),
    .buf_wr_sel(bw_sel), .buf_wr_addr(bw_addr), .buf_wr_data(wdata), .mem_wr_en(mw_en),
    .mem_wr_addr(mw_addr), .mem_wr_data(wdata), .busy(dbusy));
  sfr_host sfr_host_i (.mclk(mclk), .rst_n(rst_n), .link(link), .start(start),
    .opcode(opcode), .addr(addr), .dummy_bits(dummy_bits), .nbytes(nbytes), .busy(hbusy),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
  sfr_checker sfr_checker_i (.mclk(mclk), .rst_n(rst_n), .cs_n(link.cs_n), .sck(link.sck),
    .si(link.si), .so_o(link.so_o), .so_oe(link.so_oe), .so(link.so));
  // 100 MHz system clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // First byte seen on the wire, one bit per rising edge
  always @(posedge link.sck)
  begin
    if (link.cs_n === 1'b0 && fcnt < 8)
      seen_opc = {seen_opc[6:0], link.si};
    fcnt++;
  end
  always @(negedge link.cs_n)
    fcnt = 0;
  task automatic step();
    @(posedge mclk);
    #1;
  endtask : step
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // Buffer pattern, differs per buffer so a swapped source shows
  function automatic logic [7:0] bpat(input logic s, input int off);
    return 8'(off) ^ (s ? 8'hA5 : 8'h5A);
  endfunction : bpat
  task automatic put_mem(input logic [22:0] a, input logic [7:0] d);
    mw_addr = a;
    wdata = d;
    mw_en = 1'b1;
    step();
  endtask : put_mem
  // One read frame; bytes are taken while rx_ready is high, stalled for hold cycles
  task automatic run(input logic [7:0] op, input logic [23:0] a, input logic [7:0] dm,
    input int n, input int hold);
    int i;
    q.delete();
    opcode = op;
    addr = a;
    dummy_bits = dm;
    nbytes = 16'(n);
    start = 1'b1;
    step();
    start = 1'b0;
    for (i = 0; i < 30000 && (q.size() < n || hbusy !== 1'b0); i++)
    begin
      step();
      rx_ready = (i >= hold);
      if (i == hold && hold > 0)
      begin
        `SFR_CHECK(hbusy, 1'b1)
        `SFR_CHECK(dbusy, 1'b1)
        `SFR_CHECK(rx_valid, 1'b1)
      end
      if (rx_valid === 1'b1 && rx_ready === 1'b1)
        q.push_back(rx_data);
    end
    if (i == 30000)
    begin
      mismatches++;
      test_done();
    end
    // Deselect needs three cycles through the device; also keeps frames apart
    repeat (4) step();
    `SFR_CHECK(seen_opc, op)
    `SFR_CHECK(link.so, 1'b1)
    `SFR_CHECK(dbusy, 1'b0)
    `SFR_CHECK(rx_valid, 1'b0)
  endtask : run
  // Both buffers loaded around their end, before any array read
  task automatic t_load();
    for (int s = 0; s < 2; s++)
      for (int j = 0; j < 17; j++)
      begin
        bw_sel = s[0];
        bw_addr = 10'((520 + j) % 528);
        wdata = bpat(s[0], (520 + j) % 528);
        bw_en = 1'b1;
        step();
      end
    bw_en = 1'b0;
  endtask : t_load
  // Continuous read across a page end, reserved bit set
  task automatic t_cont();
    for (int i = 0; i < 4; i++)
      put_mem((i < 2) ? {13'h0000, 10'(526 + i)} : {13'h0001, 10'(i - 2)}, 8'h30 + 8'(i));
    mw_en = 1'b0;
    run(sfr_pkg::OP_CONT_READ, {1'b1, 13'h0000, 10'h20E}, sfr_pkg::MEM_DUMMY, 4, 0);
    for (int i = 0; i < 4; i++)
      `SFR_CHECK(q[i], 8'h30 + 8'(i))
  endtask : t_cont
  // Last byte of the array rolls to page zero
  task automatic t_wrap();
    put_mem({13'h1FFF, 10'h20F}, 8'h77);
    put_mem(23'h000000, 8'h78);
    mw_en = 1'b0;
    run(sfr_pkg::OP_CONT_READ, {1'b0, 13'h1FFF, 10'h20F}, sfr_pkg::MEM_DUMMY, 2, 0);
    `SFR_CHECK(q[0], 8'h77)
    `SFR_CHECK(q[1], 8'h78)
  endtask : t_wrap
  // Page read wraps inside its own page, next page holds a decoy
  task automatic t_page();
    put_mem({13'h0001, 10'h20F}, 8'h41);
    put_mem({13'h0001, 10'h000}, 8'h42);
    put_mem({13'h0002, 10'h000}, 8'h43);
    mw_en = 1'b0;
    run(sfr_pkg::OP_PAGE_READ, {1'b0, 13'h0001, 10'h20F}, sfr_pkg::MEM_DUMMY, 2, 0);
    `SFR_CHECK(q[0], 8'h41)
    `SFR_CHECK(q[1], 8'h42)
  endtask : t_page
  // Both buffers, ignored bits all ones, wrap at 528; first one stalls the FIFO full
  task automatic t_buf();
    for (int s = 0; s < 2; s++)
    begin
      run(s ? sfr_pkg::OP_BUF2_READ : sfr_pkg::OP_BUF1_READ, {14'h3FFF, 10'h208},
        sfr_pkg::BUF_DUMMY, 17, s ? 0 : 3000);
      for (int j = 0; j < 17; j++)
        `SFR_CHECK(q[j], bpat(s[0], (520 + j) % 528))
    end
  endtask : t_buf
  // Unknown opcode leaves the line floating, next frame still served
  task automatic t_bad();
    run(8'h0F, 24'h000000, sfr_pkg::BUF_DUMMY, 2, 0);
    `SFR_CHECK(q[0], 8'hFF)
    `SFR_CHECK(q[1], 8'hFF)
    run(sfr_pkg::OP_BUF1_READ, 24'h000208, sfr_pkg::BUF_DUMMY, 1, 0);
    `SFR_CHECK(q[0], bpat(1'b0, 520))
  endtask : t_bad
  // Reset for 20 cycles, then scenarios in order
  initial
  begin
    {rst_n, start, bw_en, bw_sel, mw_en} = 5'h00;
    rx_ready = 1'b1;
    {bw_addr, mw_addr, wdata, opcode, addr, dummy_bits, nbytes} = 97'h0;
    {mismatches, checks_done, fcnt} = 0;
    seen_opc = 8'h00;
    repeat (20) step();
    rst_n = 1'b1;
    step();
    t_load();
    t_cont();
    t_wrap();
    t_page();
    t_buf();
    t_bad();
    test_done();
  end
endmodule : testbench
